// file: hw/rscl_defines.svh
// Offsets, field positions, reset values and counts of the strap latch
`ifndef RSCL_DEFINES_SVH
`define RSCL_DEFINES_SVH

// Strap vector layout after the synchroniser
`define RSCL_PIN_COUNT 4
`define RSCL_PIN_PWR 0
`define RSCL_PIN_GANG 1
`define RSCL_PIN_LED 2
`define RSCL_PIN_MODE 3
// Pins idle high through their board pull-ups
`define RSCL_PIN_RESET 4'hF

// Cycles after reset release before the straps are taken
`define RSCL_SETTLE_CYCLES 3'h5

// Register byte offsets
`define RSCL_REG_STATUS 4'h0
`define RSCL_REG_TARGET 4'h4
`define RSCL_REG_PORTPWR 4'h8
`define RSCL_REG_LIVE 4'hC

// Status register fields
`define RSCL_ST_FULLPWR 0
`define RSCL_ST_GANGED 1
`define RSCL_ST_LEDEN 2
`define RSCL_ST_MGMT 3
`define RSCL_ST_VALID 4
`define RSCL_ST_MOVED 5
`define RSCL_ST_RAW_LO 8

// Port power control field
`define RSCL_PP_REQ 0

// Target address layout
`define RSCL_ADDR_W 7
`define RSCL_ADDR_BASE 7'h50

// Reset values
`define RSCL_ADDR_RESET 7'h00
`define RSCL_DATA_RESET 32'h00000000

`endif

// file: hw/rscl_pkg.sv
// Types shared by the strap latch design
package rscl_pkg;

	// Capture sequence after reset release
	typedef enum logic {
		RSCL_SETTLE,
		RSCL_HOLD
	} rscl_state_t;

endpackage

// file: hw/rscl_pin_sync.sv
// Three-flop pin synchroniser with agreement filter, one lane per strap
`timescale 1ns/10ps
`include "rscl_defines.svh"

module rscl_pin_sync
	import rscl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RSCL_PIN_COUNT-1:0] pinIn,
	output logic [`RSCL_PIN_COUNT-1:0] pinStable
);

	localparam logic [`RSCL_PIN_COUNT-1:0] PIN_RST = `RSCL_PIN_RESET;

	genvar i;
	generate
		for (i = 0; i < `RSCL_PIN_COUNT; i++) begin : gLane
			logic s1;
			logic s2;
			logic s3;
			logic stable;
			logic next_stable;

			// Only a level seen by both later flops is believed
			always_comb begin
				next_stable = stable;
				if (s2 == s3) begin
					next_stable = s3;
				end
			end

			// First flop feeds only the second one
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1 <= PIN_RST[i];
					s2 <= PIN_RST[i];
					s3 <= PIN_RST[i];
					stable <= PIN_RST[i];
				end else begin
					s1 <= pinIn[i];
					s2 <= s1;
					s3 <= s2;
					stable <= next_stable;
				end
			end

			assign pinStable[i] = stable;
		end
	endgenerate

endmodule // rscl_pin_sync

// file: hw/rscl_avmm_slave.sv
// Avalon-MM handshake: one wait cycle, registered read data
`timescale 1ns/10ps
`include "rscl_defines.svh"

module rscl_avmm_slave
	import rscl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readMux,
	output logic waitrequest,
	output logic [31:0] readdata,
	output logic writeAccept
);

	logic next_waitrequest;
	logic [31:0] next_readdata;

	// Drop waitrequest one cycle after a request appears, then raise it
	always_comb begin
		next_waitrequest = 1'b1;
		next_readdata = readdata;
		if (waitrequest && (read || write)) begin
			next_waitrequest = 1'b0;
			if (read) begin
				next_readdata = readMux;
			end
		end
	end

	// Write lands at the edge where the master sees waitrequest low
	assign writeAccept = write && !waitrequest;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata <= `RSCL_DATA_RESET;
		end else begin
			waitrequest <= next_waitrequest;
			readdata <= next_readdata;
		end
	end

endmodule // rscl_avmm_slave

// file: hw/rscl_strap_latch.sv
// Reset strap capture for hub power, indicator and target address options
//
// Overview of operation
// - At reset release the power strap is taken: low enables full port power management, high reports it unsupported.
// - Full power management means the port-zero power enable output switches port power; unsupported leaves it fixed on.
// - In management target mode the power strap level becomes target address bit 1.
// - At reset release the gang strap is taken: low selects per-port power and overcurrent, high selects ganged.
// - In management target mode the gang strap level becomes target address bit 2.
// - At reset release the indicator strap is taken: low enables the port indicator LEDs, high leaves them off.
// - In management target mode the indicator strap level becomes target address bit 3.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "rscl_defines.svh"

module rscl_strap_latch
	import rscl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic powerMgmtAddr1Strap,
	input wire logic sharedSwitchAddr2Strap,
	input wire logic indicatorLedAddr3Strap,
	input wire logic managementTargetModeSelect_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic fullPowerMgmtEn,
	output logic gangedPowerEn,
	output logic indicatorLedEn,
	output logic managementTargetModeEn,
	output logic [6:0] managementTargetAddr,
	output logic configValid,
	output logic port0PowerEnableOut_n
);

	localparam logic [2:0] SETTLE = `RSCL_SETTLE_CYCLES;
	localparam logic [`RSCL_PIN_COUNT-1:0] PIN_RST = `RSCL_PIN_RESET;

	logic [`RSCL_PIN_COUNT-1:0] pinRaw;
	logic [`RSCL_PIN_COUNT-1:0] pinStable;
	logic [31:0] readMux;
	logic writeAccept;

	rscl_state_t state;
	rscl_state_t next_state;
	logic [2:0] settleCount;
	logic [2:0] next_settleCount;
	logic [`RSCL_PIN_COUNT-1:0] strapLatch;
	logic [`RSCL_PIN_COUNT-1:0] next_strapLatch;
	logic next_fullPowerMgmtEn;
	logic next_gangedPowerEn;
	logic next_indicatorLedEn;
	logic next_managementTargetModeEn;
	logic [6:0] next_managementTargetAddr;
	logic next_configValid;
	logic pinMoved;
	logic next_pinMoved;
	logic powerRequest;
	logic next_powerRequest;
	logic next_port0PowerEnableOut_n;

	// Gather the shared pins in lane order
	always_comb begin
		pinRaw[`RSCL_PIN_PWR] = powerMgmtAddr1Strap;
		pinRaw[`RSCL_PIN_GANG] = sharedSwitchAddr2Strap;
		pinRaw[`RSCL_PIN_LED] = indicatorLedAddr3Strap;
		pinRaw[`RSCL_PIN_MODE] = managementTargetModeSelect_n;
	end

	rscl_pin_sync uSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(pinRaw),
		.pinStable(pinStable)
	);

	// Settle, then take the straps exactly once per reset
	always_comb begin
		next_state = state;
		next_settleCount = settleCount;
		next_strapLatch = strapLatch;
		next_fullPowerMgmtEn = fullPowerMgmtEn;
		next_gangedPowerEn = gangedPowerEn;
		next_indicatorLedEn = indicatorLedEn;
		next_managementTargetModeEn = managementTargetModeEn;
		next_managementTargetAddr = managementTargetAddr;
		next_configValid = configValid;
		case (state)
			RSCL_SETTLE: begin
				// Wait for the synchroniser to fill with real pin levels
				if (settleCount == SETTLE - 3'h1) begin
					next_state = RSCL_HOLD;
					next_strapLatch = pinStable;
					next_fullPowerMgmtEn = !pinStable[`RSCL_PIN_PWR];
					next_gangedPowerEn = pinStable[`RSCL_PIN_GANG];
					next_indicatorLedEn = !pinStable[`RSCL_PIN_LED];
					next_managementTargetModeEn = !pinStable[`RSCL_PIN_MODE];
					next_managementTargetAddr = `RSCL_ADDR_BASE;
					if (!pinStable[`RSCL_PIN_MODE]) begin
						next_managementTargetAddr[1] =
							pinStable[`RSCL_PIN_PWR];
						next_managementTargetAddr[2] =
							pinStable[`RSCL_PIN_GANG];
						next_managementTargetAddr[3] =
							pinStable[`RSCL_PIN_LED];
					end
					next_configValid = 1'b1;
				end else begin
					next_settleCount = settleCount + 3'h1;
				end
			end
			RSCL_HOLD: begin
				// Nothing changes here until the next reset
				next_state = RSCL_HOLD;
			end
			default: begin
				next_state = RSCL_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= RSCL_SETTLE;
			settleCount <= 3'h0;
			strapLatch <= PIN_RST;
			fullPowerMgmtEn <= 1'b0;
			gangedPowerEn <= 1'b0;
			indicatorLedEn <= 1'b0;
			managementTargetModeEn <= 1'b0;
			managementTargetAddr <= `RSCL_ADDR_RESET;
			configValid <= 1'b0;
		end else begin
			state <= next_state;
			settleCount <= next_settleCount;
			strapLatch <= next_strapLatch;
			fullPowerMgmtEn <= next_fullPowerMgmtEn;
			gangedPowerEn <= next_gangedPowerEn;
			indicatorLedEn <= next_indicatorLedEn;
			managementTargetModeEn <= next_managementTargetModeEn;
			managementTargetAddr <= next_managementTargetAddr;
			configValid <= next_configValid;
		end
	end

	// Sticky flag: pins moved after capture, write one to clear
	always_comb begin
		next_pinMoved = pinMoved;
		if (writeAccept && avs_address == `RSCL_REG_STATUS &&
			avs_byteenable[0] && avs_writedata[`RSCL_ST_MOVED]) begin
			next_pinMoved = 1'b0;
		end
		// Set beats a clear in the same cycle
		if (state == RSCL_HOLD && pinStable != strapLatch) begin
			next_pinMoved = 1'b1;
		end
	end

	// Software port power request
	always_comb begin
		next_powerRequest = powerRequest;
		if (writeAccept && avs_address == `RSCL_REG_PORTPWR &&
			avs_byteenable[0]) begin
			next_powerRequest = avs_writedata[`RSCL_PP_REQ];
		end
	end

	// Port power pin switches only with full power management
	always_comb begin
		next_port0PowerEnableOut_n = 1'b1;
		if (configValid) begin
			if (fullPowerMgmtEn) begin
				next_port0PowerEnableOut_n = !powerRequest;
			end else begin
				// No switching offered: ports stay powered
				next_port0PowerEnableOut_n = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinMoved <= 1'b0;
			powerRequest <= 1'b0;
			port0PowerEnableOut_n <= 1'b1;
		end else begin
			pinMoved <= next_pinMoved;
			powerRequest <= next_powerRequest;
			port0PowerEnableOut_n <= next_port0PowerEnableOut_n;
		end
	end

	// Read decode; unmapped offsets return zero
	always_comb begin
		readMux = `RSCL_DATA_RESET;
		if (avs_address == `RSCL_REG_STATUS) begin
			readMux[`RSCL_ST_FULLPWR] = fullPowerMgmtEn;
			readMux[`RSCL_ST_GANGED] = gangedPowerEn;
			readMux[`RSCL_ST_LEDEN] = indicatorLedEn;
			readMux[`RSCL_ST_MGMT] = managementTargetModeEn;
			readMux[`RSCL_ST_VALID] = configValid;
			readMux[`RSCL_ST_MOVED] = pinMoved;
			readMux[`RSCL_ST_RAW_LO+:`RSCL_PIN_COUNT] = strapLatch;
		end else if (avs_address == `RSCL_REG_TARGET) begin
			readMux[`RSCL_ADDR_W-1:0] = managementTargetAddr;
		end else if (avs_address == `RSCL_REG_PORTPWR) begin
			readMux[`RSCL_PP_REQ] = powerRequest;
		end else if (avs_address == `RSCL_REG_LIVE) begin
			// Live levels let software see pins reused after reset
			readMux[`RSCL_PIN_COUNT-1:0] = pinStable;
		end
	end

	rscl_avmm_slave uBus (
		.clk(clk),
		.rst_n(rst_n),
		.read(avs_read),
		.write(avs_write),
		.readMux(readMux),
		.waitrequest(avs_waitrequest),
		.readdata(avs_readdata),
		.writeAccept(writeAccept)
	);

endmodule // rscl_strap_latch

// file: tb/rscl_strap_board.sv
// Board model of the strap pins: pull-ups unless the bench drives them
`timescale 1ns/10ps

module rscl_strap_board (
	input wire logic [3:0] drv,
	input wire logic [3:0] drvEn,
	output logic [3:0] pins
);
	// Undriven straps rest high through their pull-ups
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pins[i] = drvEn[i] ? drv[i] : 1'b1;
		end
	end
endmodule // rscl_strap_board

// file: tb/rscl_strap_latch_asserts.sv
// Checker for strap capture and hold at the latch's ports
`timescale 1ns/10ps

module rscl_strap_latch_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic powerMgmtAddr1Strap,
	input wire logic sharedSwitchAddr2Strap,
	input wire logic indicatorLedAddr3Strap,
	input wire logic fullPowerMgmtEn,
	input wire logic gangedPowerEn,
	input wire logic indicatorLedEn,
	input wire logic managementTargetModeEn,
	input wire logic [6:0] managementTargetAddr,
	input wire logic configValid,
	input wire logic port0PowerEnableOut_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Pins are held steady around capture, so two cycles back is safe
	a_pwr_sample: assert property ($rose(configValid) |->
		fullPowerMgmtEn == !$past(powerMgmtAddr1Strap, 2))
		else $error("power strap captured wrongly");
	a_gang_sample: assert property ($rose(configValid) |->
		gangedPowerEn == $past(sharedSwitchAddr2Strap, 2))
		else $error("gang strap captured wrongly");
	a_led_sample: assert property ($rose(configValid) |->
		indicatorLedEn == !$past(indicatorLedAddr3Strap, 2))
		else $error("indicator strap captured wrongly");
	a_addr_bit1: assert property (
		configValid && managementTargetModeEn |->
		managementTargetAddr[1] == !fullPowerMgmtEn)
		else $error("target address bit 1 wrong");
	a_addr_bit2: assert property (
		configValid && managementTargetModeEn |->
		managementTargetAddr[2] == gangedPowerEn)
		else $error("target address bit 2 wrong");
	a_addr_bit3: assert property (
		configValid && managementTargetModeEn |->
		managementTargetAddr[3] == !indicatorLedEn)
		else $error("target address bit 3 wrong");
	a_port_fixed: assert property (
		configValid && !fullPowerMgmtEn |=> !port0PowerEnableOut_n)
		else $error("port power not fixed on");
	a_config_hold: assert property (configValid |=> configValid &&
		$stable({fullPowerMgmtEn, gangedPowerEn, indicatorLedEn,
		managementTargetModeEn, managementTargetAddr}))
		else $error("captured strap values moved");
endmodule // rscl_strap_latch_asserts

bind rscl_strap_latch rscl_strap_latch_asserts chk (
	.clk(clk),
	.rst_n(rst_n),
	.powerMgmtAddr1Strap(powerMgmtAddr1Strap),
	.sharedSwitchAddr2Strap(sharedSwitchAddr2Strap),
	.indicatorLedAddr3Strap(indicatorLedAddr3Strap),
	.fullPowerMgmtEn(fullPowerMgmtEn),
	.gangedPowerEn(gangedPowerEn),
	.indicatorLedEn(indicatorLedEn),
	.managementTargetModeEn(managementTargetModeEn),
	.managementTargetAddr(managementTargetAddr),
	.configValid(configValid),
	.port0PowerEnableOut_n(port0PowerEnableOut_n)
);

// file: tb/rscl_strap_latch_tb.sv
// Self-checking bench for the reset strap latch
`timescale 1ns/10ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module rscl_strap_latch_tb;
	import rscl_pkg::*;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0;
	logic [3:0] drv = 4'hF, drvEn = 4'hF, pins, adr = 4'h0, s;
	logic [3:0] mv, be = 4'hF;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [6:0] tAddr;
	logic wq, pwrEn, gangEn, ledEn, modeEn, cfgOk, p0_n;
	int n_fail = 0, num_checks = 0, seed = 66983;

	always #20 clk = ~clk;

	rscl_strap_board board (.drv(drv), .drvEn(drvEn), .pins(pins));
	rscl_strap_latch dut (.clk(clk), .rst_n(rst_n),
		.powerMgmtAddr1Strap(pins[0]), .sharedSwitchAddr2Strap(pins[1]),
		.indicatorLedAddr3Strap(pins[2]),
		.managementTargetModeSelect_n(pins[3]), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
		.fullPowerMgmtEn(pwrEn), .gangedPowerEn(gangEn),
		.indicatorLedEn(ledEn), .managementTargetModeEn(modeEn),
		.managementTargetAddr(tAddr), .configValid(cfgOk),
		.port0PowerEnableOut_n(p0_n));

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		rd <= !w; wr <= w; adr <= a; wd <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wq === 1'b0) break;
		end
		q = rdat;
		rd <= 1'b0; wr <= 1'b0;
		if (k == 20) begin n_fail++; conclude(); end
	endtask

	// Expected outputs come from the strap levels alone
	task check_outs;
		`CHK(pwrEn, !s[0])
		`CHK(gangEn, s[1])
		`CHK(ledEn, !s[2])
		`CHK(modeEn, !s[3])
		`CHK(p0_n, s[0] ? 1'b0 : 1'b1)
		`CHK(cfgOk, 1'b1)
		`CHK(tAddr, s[3] ? 7'h50 : 7'h50 | {3'h0, s[2:0], 1'b0})
	endtask

	initial begin
		for (int i = 0; i < 20; i++) begin
			s = (i < 16) ? 4'(i) : 4'($random(seed));
			@(posedge clk);
			rst_n <= 1'b0; drv <= s; drvEn <= (s == 4'hF) ? 4'h0 : 4'hF;
			repeat (8) @(posedge clk);
			rst_n <= 1'b1;
			repeat (9) @(posedge clk);
			check_outs();
			bus(1'b0, 4'h0, 32'h0);
			`CHK(q, {20'h0, s, 3'h0, 1'b1, ~s[3], ~s[2], s[1], ~s[0]})
			bus(1'b0, 4'h4, 32'h0);
			`CHK(q[6:0], s[3] ? 7'h50 : 7'h50 | {3'h0, s[2:0], 1'b0})
			bus(1'b0, 4'h2, 32'h0);
			`CHK(q, 32'h0)
			// A write without byte lane 0 leaves the request alone
			be <= 4'hE;
			bus(1'b1, 4'h8, 32'h1);
			be <= 4'hF;
			bus(1'b0, 4'h8, 32'h0);
			`CHK(q, 32'h0)
			// Port power follows the request only with full management
			bus(1'b1, 4'h8, 32'h1);
			repeat (2) @(posedge clk);
			`CHK(p0_n, 1'b0)
			bus(1'b0, 4'h8, 32'h0);
			`CHK(q, 32'h1)
			bus(1'b1, 4'h8, 32'h0);
			repeat (2) @(posedge clk);
			`CHK(p0_n, s[0] ? 1'b0 : 1'b1)
			// Pins reused after capture must not touch the held values
			mv = 4'($random(seed));
			drv <= mv;
			drvEn <= 4'hF;
			repeat (10) @(posedge clk);
			check_outs();
			bus(1'b0, 4'hC, 32'h0);
			`CHK(q, {28'h0, mv})
			// Clear while the pins still differ: the set wins
			bus(1'b1, 4'h0, 32'h20);
			bus(1'b0, 4'h0, 32'h0);
			`CHK(q[5], mv != s)
			drv <= s;
			repeat (6) @(posedge clk);
			bus(1'b1, 4'h0, 32'h20);
			bus(1'b0, 4'h0, 32'h0);
			`CHK(q, {20'h0, s, 3'h0, 1'b1, ~s[3], ~s[2], s[1], ~s[0]})
		end
		conclude();
	end
endmodule // rscl_strap_latch_tb
